// ### irq_pkg.sv
// What this block does
// - mask register at 0x20, reset clears it
// - one pending latch per source
// - sample at last instruction cycle, service highest
// - acknowledge clears mask and latch and starts call, same cycle
// - call pushes pc with carry and zero
// - vectors two bytes apart, priority order
// - latency: remaining cycles plus ten plus five
// - new interrupts once firmware re-enables mask
// - pin edge polarity from pull-up bit
// - write-only pin enables at 0x04, 0x05
// - gated detects ORed, rising OR sets flop
// - flop qualified by global gpio enable
// - no new pin event until OR falls
// - enable toggle on held pin retriggers
// - ack keeps pin enables, no pin priority
// - endpoint zero event, mask bit 3
// - nakked out packet raises nothing
// - endpoint one tx ack, mask bit 4
// - timer ticks masked by bits 1, 2
// - wake-up pin rising edge latched, bit 7
// - pull-up registers 0x08, 0x09, cleared
package irq_pkg;
  localparam logic [7:0] GlobalIrqMaskAddr = 8'h20;
  localparam logic [7:0] Port0PinIrqEnableAddr = 8'h04;
  localparam logic [7:0] Port1PinIrqEnableAddr = 8'h05;
  localparam logic [7:0] Port0PullupAddr = 8'h08;
  localparam logic [7:0] Port1PullupAddr = 8'h09;
  localparam logic [7:0] RegResetVal = 8'h00;
  localparam logic [7:0] MaskWritable = 8'hDE;
  localparam int FastTickBit = 1;
  localparam int SlowTickBit = 2;
  localparam int EndpointZeroBit = 3;
  localparam int EndpointOneBit = 4;
  localparam int PortPinBit = 6;
  localparam int WakeupBit = 7;
  localparam int NumSrc = 8;
  localparam int CallCycles = 10;
  localparam int JumpCycles = 5;
  localparam int VectorStep = 2;
  localparam logic [4:0] CallCyclesW = 5'(CallCycles);
  localparam logic [4:0] JumpCyclesW = 5'(JumpCycles);
  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    CALL_ST = 2'b01,
    JUMP_ST = 2'b10
  } ack_state_type;
endpackage

// ### io_bus_if.sv
`timescale 1ns/1ps
// internal carrier of the i/o write strobe
interface io_bus_if;
  logic wrEn;
  logic [7:0] addr;
  logic [7:0] data;
  modport src (output wrEn, addr, data);
  modport dst (input wrEn, addr, data);
endinterface

// ### pin_edge_or.sv
`timescale 1ns/1ps
// per-pin polarity match, enable gate and OR, with rising detect of the OR
module pin_edge_or #(
  parameter int Width = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [Width-1:0] pinSync, // synchronised pin levels
  input wire logic [Width-1:0] polarity, // 1 rising, 0 falling
  input wire logic [Width-1:0] pinEn, // per-pin enables
  output logic orRise // one-cycle pulse on OR rise
);
  logic [Width-1:0] pinPrev_q;
  logic orOut_q;
  wire [Width-1:0] pinActive = ~(pinSync ^ polarity);
  wire [Width-1:0] pinEdge = (pinSync ^ pinPrev_q) & pinActive;
  // detect holds while the pin stays at its trigger level
  logic [Width-1:0] held_q;
  wire [Width-1:0] heldD = (held_q | pinEdge) & pinActive;
  wire orD = |(heldD & pinEn);
  initial begin
    if (Width < 1) $error("width must be positive");
  end
  // pin history and OR flop
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pinPrev_q <= '0;
      held_q <= '0;
      orOut_q <= 1'b0;
    end else begin
      pinPrev_q <= pinSync;
      held_q <= heldD;
      orOut_q <= orD;
    end
  end
  assign orRise = orD & ~orOut_q;
endmodule

// ### irq_controller.sv
`timescale 1ns/1ps
// prioritised latching interrupt controller
module irq_controller
  import irq_pkg::*;
#(
  parameter int PinWidth = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_b, // sync reset, active low
  input wire logic ioWrite, // core i/o write strobe
  input wire logic [7:0] ioAddr, // i/o address
  input wire logic [7:0] ioWrData, // i/o write data
  input wire logic ioRead, // core i/o read strobe
  output logic [7:0] ioRdData, // mask read data
  input wire logic lastCycle, // last cycle of current instruction
  input wire logic fastTick, // fast timer tick pulse
  input wire logic slowTick, // slow timer tick pulse
  input wire logic endpointZeroRx, // host data accepted on ep0
  input wire logic endpointZeroNak, // ep0 out packet was nakked
  input wire logic endpointZeroTxAck, // ep0 tx acked by host
  input wire logic endpointOneTxAck, // ep1 tx acked by host
  input wire logic [PinWidth-1:0] portPins, // async port pins
  input wire logic wakeupPin, // async wake-up pin
  input wire logic [10:0] pcIn, // current program counter
  input wire logic carryFlag, // carry flag
  input wire logic zeroFlag, // zero flag
  output logic irqCall, // call in progress, core stalls
  output logic callPush, // one-cycle push strobe
  output logic [12:0] pushData, // pc, carry, zero to push
  output logic [7:0] vectorAddr, // vector target
  output logic vectorJump, // one-cycle pulse into vector
  output logic irqPending // any enabled request
);
  import irq_pkg::*;
  io_bus_if bus();
  ack_state_type state_q;
  logic [7:0] mask_q;
  logic [7:0] pend_q;
  logic [7:0] p0En_q;
  logic [7:0] p1En_q;
  logic [7:0] p0Pull_q;
  logic [7:0] p1Pull_q;
  logic [PinWidth-1:0] pinMeta_q;
  logic [PinWidth-1:0] pinSync_q;
  logic wakeMeta_q;
  logic wakeSync_q;
  logic wakePrev_q;
  logic [4:0] cnt_q;
  logic [2:0] srcIdx_q;
  logic [7:0] rdData_q;
  logic call_q;
  logic push_q;
  logic [12:0] pushData_q;
  logic [7:0] vec_q;
  logic jump_q;
  logic anyReq_q;
  logic gpioRise;
  initial begin
    if (PinWidth < 1 || PinWidth > 16) $error("pin width must be 1..16");
  end
  // i/o write carrier
  assign bus.wrEn = ioWrite;
  assign bus.addr = ioAddr;
  assign bus.data = ioWrData;
  // register decode
  wire maskWr = bus.wrEn && bus.addr == GlobalIrqMaskAddr;
  wire p0EnWr = bus.wrEn && bus.addr == Port0PinIrqEnableAddr;
  wire p1EnWr = bus.wrEn && bus.addr == Port1PinIrqEnableAddr;
  wire p0PullWr = bus.wrEn && bus.addr == Port0PullupAddr;
  wire p1PullWr = bus.wrEn && bus.addr == Port1PullupAddr;
  // pin enables and polarity spread over the pin width
  wire [15:0] allEn = {p1En_q, p0En_q};
  wire [15:0] allPull = {p1Pull_q, p0Pull_q};
  // gated requests and priority pick; bit 0 has no source
  wire [7:0] req = pend_q & mask_q & MaskWritable;
  wire anyReq = |req;
  logic [2:0] pick;
  always_comb begin
    pick = 3'd0;
    for (int i = NumSrc - 1; i >= 1; i--) begin
      if (req[i]) pick = 3'(i);
    end
  end
  wire takeIrq = (state_q == IDLE_ST) && lastCycle && anyReq;
  // source events
  wire wakeRise = wakeSync_q & ~wakePrev_q;
  wire ep0Ev = endpointZeroRx & ~endpointZeroNak | endpointZeroTxAck;
  wire [7:0] srcEv = {wakeRise, gpioRise, 1'b0, endpointOneTxAck, ep0Ev,
                      slowTick, fastTick, 1'b0};
  // acknowledge clears the serviced latch
  wire [7:0] ackClr = takeIrq ? (8'h01 << pick) : 8'h00;
  wire [7:0] pendD = (pend_q & ~ackClr) | srcEv;
  // mask: cleared wholesale on acknowledge, reserved bits stay zero
  wire [7:0] maskD = takeIrq ? 8'h00 :
                     maskWr ? (bus.data & MaskWritable) : mask_q;
  pin_edge_or #(
    .Width(PinWidth)
  ) u_pins (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinSync(pinSync_q),
    .polarity(allPull[PinWidth-1:0]),
    .pinEn(allEn[PinWidth-1:0]),
    .orRise(gpioRise)
  );
  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
      wakeMeta_q <= 1'b0;
      wakeSync_q <= 1'b0;
      wakePrev_q <= 1'b0;
    end else begin
      pinMeta_q <= portPins;
      pinSync_q <= pinMeta_q;
      wakeMeta_q <= wakeupPin;
      wakeSync_q <= wakeMeta_q;
      wakePrev_q <= wakeSync_q;
    end
  end
  // write-only configuration registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      p0En_q <= RegResetVal;
      p1En_q <= RegResetVal;
      p0Pull_q <= RegResetVal;
      p1Pull_q <= RegResetVal;
    end else begin
      if (p0EnWr) p0En_q <= bus.data;
      if (p1EnWr) p1En_q <= bus.data;
      if (p0PullWr) p0Pull_q <= bus.data;
      if (p1PullWr) p1Pull_q <= bus.data;
    end
  end
  // mask and pending latches
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mask_q <= RegResetVal;
      pend_q <= RegResetVal;
    end else begin
      mask_q <= maskD;
      pend_q <= pendD;
    end
  end
  // mask readback
  always_ff @(posedge core_clk) begin
    if (!rst_b) rdData_q <= RegResetVal;
    else if (ioRead && ioAddr == GlobalIrqMaskAddr) rdData_q <= mask_q;
    else rdData_q <= 8'h00;
  end
  // acknowledge sequencer: call then jump slot
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= IDLE_ST;
      cnt_q <= 5'd0;
      srcIdx_q <= 3'd0;
      call_q <= 1'b0;
      push_q <= 1'b0;
      pushData_q <= '0;
      vec_q <= 8'h00;
      jump_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      jump_q <= 1'b0;
      case (state_q)
        IDLE_ST: begin
          if (takeIrq) begin
            state_q <= CALL_ST;
            cnt_q <= CallCyclesW - 5'd1;
            srcIdx_q <= pick;
            call_q <= 1'b1;
            push_q <= 1'b1;
            pushData_q <= {pcIn, carryFlag, zeroFlag};
            vec_q <= 8'(pick * VectorStep);
          end
        end
        CALL_ST: begin
          if (cnt_q == 5'd0) begin
            state_q <= JUMP_ST;
            cnt_q <= JumpCyclesW - 5'd1;
            jump_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        JUMP_ST: begin
          if (cnt_q == 5'd0) begin
            state_q <= IDLE_ST;
            call_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        default: begin
          state_q <= IDLE_ST;
          call_q <= 1'b0;
        end
      endcase
    end
  end
  // pending request flag
  always_ff @(posedge core_clk) begin
    if (!rst_b) anyReq_q <= 1'b0;
    else anyReq_q <= anyReq;
  end
  assign ioRdData = rdData_q;
  assign irqCall = call_q;
  assign callPush = push_q;
  assign pushData = pushData_q;
  assign vectorAddr = vec_q;
  assign vectorJump = jump_q;
  assign irqPending = anyReq_q;
endmodule

// ### core_model.sv
`timescale 1ns/1ps
// core stand-in: two- and four-cycle instructions, frozen during a call
module core_model (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic irqCall, // stall
  output logic lastCycle, // boundary
  output logic [10:0] pcIn, // pc
  output logic carryFlag, // carry
  output logic zeroFlag // zero
);
  logic [1:0] phaseQ = 2'h0;
  initial pcIn = 11'h000;
  // instruction length follows pc bit 3, flags follow pc
  assign lastCycle = (irqCall !== 1'b1) && phaseQ == (pcIn[3] ? 2'h3 : 2'h1);
  assign carryFlag = pcIn[4];
  assign zeroFlag = pcIn[5];
  // advance on falling edges
  always @(negedge core_clk) begin
    if (!rst_b) begin
      phaseQ <= 2'h0;
      pcIn <= 11'h000;
    end else if (lastCycle) begin
      phaseQ <= 2'h0;
      pcIn <= pcIn + 11'h007;
    end else if (irqCall !== 1'b1) begin
      phaseQ <= phaseQ + 2'h1;
    end
  end
endmodule

// ### irq_monitor.sv
`timescale 1ns/1ps
// watches call sequencing and mask reads
module irq_monitor (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset
  input wire logic [7:0] ioRdData, // read data
  input wire logic lastCycle, // boundary
  input wire logic [10:0] pcIn, // pc
  input wire logic carryFlag, // carry
  input wire logic zeroFlag, // zero
  input wire logic irqCall, // call busy
  input wire logic callPush, // push
  input wire logic [12:0] pushData, // pushed state
  input wire logic [7:0] vectorAddr, // vector
  input wire logic vectorJump // jump
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // call window, push and jump timing
  call_len_a: assert property ($rose(irqCall) |-> irqCall[*8] ##1 irqCall[*7] ##1 !irqCall)
    else $error("call length");
  push_start_a: assert property ($rose(irqCall) |-> callPush)
    else $error("push missing");
  jump_gap_a: assert property (callPush |=> !vectorJump[*8] ##1 !vectorJump ##1 vectorJump)
    else $error("jump timing");
  ack_edge_a: assert property ($rose(irqCall) |-> $past(lastCycle))
    else $error("ack off boundary");
  vec_set_a: assert property (callPush |->
    vectorAddr inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h0E}) else $error("bad vector");
  push_val_a: assert property (callPush |->
    pushData == {$past(pcIn), $past(carryFlag), $past(zeroFlag)}) else $error("bad push");
  // reset and reserved bits
  rst_clear_a: assert property (disable iff (1'b0) !rst_b |=> ioRdData == 8'h00 && !irqCall)
    else $error("reset state");
  resv_zero_a: assert property (ioRdData[0] == 1'b0 && ioRdData[5] == 1'b0)
    else $error("reserved bit set");
  cover property (callPush && vectorAddr == 8'h0C);
  cover property (callPush && vectorAddr == 8'h0E);
  cover property (vectorJump);
endmodule
bind irq_controller irq_monitor mon (.core_clk, .rst_b, .ioRdData, .lastCycle, .pcIn,
  .carryFlag, .zeroFlag, .irqCall, .callPush, .pushData, .vectorAddr, .vectorJump);

// ### prioritized_interrupt_controller_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module prioritized_interrupt_controller_tb;
  import irq_pkg::*;
  logic core_clk = 0, rst_b = 0, ioWrite = 0, ioRead = 0, wakeupPin = 0;
  logic fastTick = 0, slowTick = 0, endpointZeroRx = 0, endpointZeroNak = 0;
  logic endpointZeroTxAck = 0, endpointOneTxAck = 0;
  logic lastCycle, carryFlag, zeroFlag, irqCall, callPush, vectorJump, irqPending;
  logic [7:0] ioAddr = 8'h00, ioWrData = 8'h00, ioRdData, vectorAddr;
  logic [15:0] portPins = 16'h0100;
  logic [10:0] pcIn;
  logic [12:0] pushData;
  logic [7:0] vecs [5] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0E};
  int fails = 0, check_count = 0, cycles = 0;
  irq_controller #(.PinWidth(16)) uut (.core_clk, .rst_b, .ioWrite, .ioAddr, .ioWrData,
    .ioRead, .ioRdData, .lastCycle, .fastTick, .slowTick, .endpointZeroRx, .endpointZeroNak,
    .endpointZeroTxAck, .endpointOneTxAck, .portPins, .wakeupPin, .pcIn, .carryFlag,
    .zeroFlag, .irqCall, .callPush, .pushData, .vectorAddr, .vectorJump, .irqPending);
  core_model core (.core_clk, .rst_b, .irqCall, .lastCycle, .pcIn, .carryFlag, .zeroFlag);
  initial forever #2 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    ioWrite = 1;
    ioAddr = a;
    ioWrData = d;
    @(negedge core_clk);
    ioWrite = 0;
  endtask
  task automatic mask(input logic [7:0] d);
    wr(GlobalIrqMaskAddr, d);
  endtask
  task automatic rd(input logic [7:0] exp);
    @(negedge core_clk);
    ioRead = 1;
    ioAddr = GlobalIrqMaskAddr;
    @(negedge core_clk);
    ioRead = 0;
    `CHK(ioRdData, exp)
  endtask
  // pulse the event inputs for one cycle
  task automatic src(input logic [4:0] v);
    @(negedge core_clk);
    {fastTick, slowTick, endpointZeroRx, endpointZeroTxAck, endpointOneTxAck} = v;
    @(negedge core_clk);
    {fastTick, slowTick, endpointZeroRx, endpointZeroTxAck, endpointOneTxAck} = 5'h00;
  endtask
  // wait for the push strobe, check vector, then wait out the call
  task automatic ack(input logic [7:0] exp);
    int n;
    n = 0;
    while (callPush !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(callPush, 1'b1)
    `CHK(vectorAddr, exp)
    while (irqCall === 1'b1) @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b = 1;
    rd(RegResetVal);
    mask(8'hFF);
    rd(MaskWritable);
    mask(8'h00);
    $display("reset test done");
    src(5'h10);
    repeat (12) @(negedge core_clk);
    `CHK(irqPending, 1'b0)
    mask(8'h02);
    ack(8'h02);
    rd(8'h00);
    $display("mask test done");
    src(5'h1F);
    wakeupPin = 1;
    foreach (vecs[i]) begin
      mask(8'h9E);
      ack(vecs[i]);
    end
    wakeupPin = 0;
    $display("priority test done");
    endpointZeroNak = 1;
    src(5'h04);
    endpointZeroNak = 0;
    mask(8'h08);
    repeat (12) @(negedge core_clk);
    `CHK(irqPending, 1'b0)
    src(5'h02);
    ack(8'h06);
    src(5'h01);
    mask(8'h10);
    ack(8'h08);
    $display("endpoint test done");
    wr(Port0PullupAddr, 8'h03);
    wr(Port0PinIrqEnableAddr, 8'h03);
    mask(8'h40);
    portPins[0] = 1;
    ack(8'h0C);
    mask(8'h40);
    portPins[1] = 1;
    repeat (12) @(negedge core_clk);
    `CHK(irqPending, 1'b0)
    wr(Port0PinIrqEnableAddr, 8'h00);
    wr(Port0PinIrqEnableAddr, 8'h03);
    ack(8'h0C);
    portPins = 16'h0100;
    mask(8'h40);
    portPins[1] = 1;
    ack(8'h0C);
    portPins[1] = 0;
    wr(Port1PinIrqEnableAddr, 8'h01);
    mask(8'h40);
    portPins[8] = 0;
    ack(8'h0C);
    rd(8'h00);
    mask(8'h00);
    $display("pin test done");
    complete_run();
  end
endmodule
